// ==== rie_core.sv ====
`timescale 1ns/1ps
`include "rie_params.svh"
module rie_core
    import rie_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [13:0] instr,
    input wire logic instr_valid,
    input wire logic [12:0] stack_top,
    input wire logic [7:0] irq_control_in,
    output logic stack_pop,
    output logic [12:0] pc_ff,
    output logic pc_load,
    output logic [7:0] acc_ff,
    output logic acc_load,
    output logic [7:0] irq_control_reg,
    output logic irq_control_we,
    output logic status_we,
    output logic busy,
    output logic cycle_end,
    output logic [1:0] osc_phase_ff
);
    rie_kind_t kind;
    rie_ctl_t ctl;
    rie_state_t state_ff;
    rie_state_t nxt_state;
    logic [12:0] nxt_pc;
    logic [7:0] nxt_acc;
    logic [7:0] nxt_irq;
    logic [1:0] nxt_phase;

    rie_decode i_rie_decode (
        .instr(instr),
        .kind(kind),
        .ctl(ctl)
    );

    // RULE10 four oscillator phases per cycle
    assign cycle_end = ce && (osc_phase_ff == 2'(`RIE_OSC_PER_CYC - 1));
    assign nxt_phase = cycle_end ? 2'h0 : osc_phase_ff + 2'h1;

    // Act on a decoded return only in the execute state
    wire exec_ret = (state_ff == RIE_EXEC) && instr_valid && ctl.pop;
    wire fire = exec_ret && cycle_end;

    // RULE9 flush cycle marks the no-op
    assign busy = (state_ff == RIE_FLUSH);

    // RULE3 RULE6 RULE8 one flush cycle after any return
    always_comb begin
        case (state_ff)
            RIE_EXEC: begin
                nxt_state = fire ? RIE_FLUSH : RIE_EXEC;
            end
            RIE_FLUSH: begin
                nxt_state = cycle_end ? RIE_EXEC : RIE_FLUSH;
            end
            default: begin
                nxt_state = RIE_EXEC;
            end
        endcase
    end

    // RULE1 RULE5 RULE7 pop stack into pc
    assign stack_pop = fire;
    assign pc_load = fire;
    assign nxt_pc = fire ? stack_top : pc_ff;
    // RULE4 accumulator gets literal
    assign acc_load = fire && ctl.load_acc;
    assign nxt_acc = acc_load ? ctl.literal : acc_ff;
    // RULE2 set global_irq_enable bit
    assign irq_control_we = fire && ctl.set_gie;
    assign nxt_irq = irq_control_in | (8'h01 << `RIE_GIE_BIT);
    // RULE11 status never written
    assign status_we = 1'b0;

    // State and phase registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= RIE_EXEC;
            osc_phase_ff <= 2'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            osc_phase_ff <= nxt_phase;
        end
    end

    // Datapath registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            pc_ff <= `RIE_PC_RST;
            acc_ff <= `RIE_ACC_RST;
            irq_control_reg <= `RIE_IRQ_RST;
        end else if (ce) begin
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            if (irq_control_we) begin
                irq_control_reg <= nxt_irq;
            end
        end
    end

    // Helper: count instruction cycles of a return
    logic [1:0] ret_cycles_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ret_cycles_ff <= 2'h0;
        end else if (ce && cycle_end) begin
            ret_cycles_ff <= fire ? 2'h1 : (busy ? 2'h2 : 2'h0);
        end
    end

    property p_pop_loads_pc;
        @(posedge mclk) disable iff (rst)
        (fire && ce) |=> (pc_ff == $past(stack_top));
    endproperty
    a_pop_loads_pc: assert property (p_pop_loads_pc) else $error("pc not loaded"); // RULE1

    property p_iret_pop;
        @(posedge mclk) disable iff (rst)
        (exec_ret && kind == RIE_K_IRET && cycle_end) |-> stack_pop && pc_load;
    endproperty
    a_iret_pop: assert property (p_iret_pop) else $error("iret no pop"); // RULE1

    property p_gie_set;
        @(posedge mclk) disable iff (rst)
        (fire && ce && kind == RIE_K_IRET) |=> irq_control_reg[`RIE_GIE_BIT];
    endproperty
    a_gie_set: assert property (p_gie_set) else $error("gie not set"); // RULE2

    property p_two_cycles;
        @(posedge mclk) disable iff (rst)
        (fire && ce) |=> busy && (osc_phase_ff == 2'h0);
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("bad length"); // RULE3

    property p_literal;
        @(posedge mclk) disable iff (rst)
        (fire && ce && kind == RIE_K_LRET) |=> (acc_ff == $past(instr[7:0]));
    endproperty
    a_literal: assert property (p_literal) else $error("acc wrong"); // RULE4

    property p_no_acc;
        @(posedge mclk) disable iff (rst)
        (fire && kind != RIE_K_LRET) |=> $stable(acc_ff);
    endproperty
    a_no_acc: assert property (p_no_acc) else $error("acc changed"); // RULE4

    property p_lret_pop;
        @(posedge mclk) disable iff (rst)
        (exec_ret && kind == RIE_K_LRET && cycle_end) |-> stack_pop && pc_load;
    endproperty
    a_lret_pop: assert property (p_lret_pop) else $error("lret no pop"); // RULE5

    property p_lret_len;
        @(posedge mclk) disable iff (rst)
        (fire && kind == RIE_K_LRET) |=> busy && (osc_phase_ff == 2'h0);
    endproperty
    a_lret_len: assert property (p_lret_len) else $error("lret length wrong"); // RULE6

    property p_sret_gie;
        @(posedge mclk) disable iff (rst)
        (kind == RIE_K_SRET) |-> !irq_control_we;
    endproperty
    a_sret_gie: assert property (p_sret_gie) else $error("sret touched gie"); // RULE7

    property p_sret_pop;
        @(posedge mclk) disable iff (rst)
        (exec_ret && kind == RIE_K_SRET && cycle_end) |-> stack_pop && pc_load;
    endproperty
    a_sret_pop: assert property (p_sret_pop) else $error("sret no pop"); // RULE7

    property p_gie_keep;
        @(posedge mclk) disable iff (rst)
        (fire && kind == RIE_K_SRET) |=> $stable(irq_control_reg);
    endproperty
    a_gie_keep: assert property (p_gie_keep) else $error("sret changed irq"); // RULE7

    property p_flush_nop;
        @(posedge mclk) disable iff (rst)
        busy |-> !stack_pop && !pc_load && !acc_load && !irq_control_we;
    endproperty
    a_flush_nop: assert property (p_flush_nop) else $error("flush acted"); // RULE9

    property p_flush_end;
        @(posedge mclk) disable iff (rst)
        (busy && cycle_end) |=> !busy;
    endproperty
    a_flush_end: assert property (p_flush_end) else $error("flush too long"); // RULE9

    property p_phase;
        @(posedge mclk) disable iff (rst)
        (ce && cycle_end) |=> (osc_phase_ff == 2'h0);
    endproperty
    a_phase: assert property (p_phase) else $error("phase wrong"); // RULE10

    property p_frozen;
        @(posedge mclk) disable iff (rst)
        !ce |=> $stable(osc_phase_ff) && $stable(state_ff) && $stable(pc_ff) && $stable(acc_ff);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while frozen"); // RULE10

    property p_no_status;
        @(posedge mclk) disable iff (rst)
        !status_we;
    endproperty
    a_no_status: assert property (p_no_status) else $error("status written"); // RULE11

    property p_cnt;
        @(posedge mclk) disable iff (rst)
        (ret_cycles_ff == 2'h2) |-> !busy;
    endproperty
    a_cnt: assert property (p_cnt) else $error("too many cycles"); // RULE8

    property p_sret_len;
        @(posedge mclk) disable iff (rst)
        (fire && kind == RIE_K_SRET) |=> busy && (osc_phase_ff == 2'h0);
    endproperty
    a_sret_len: assert property (p_sret_len) else $error("sret length wrong"); // RULE8

    c_iret: cover property (@(posedge mclk) fire && kind == RIE_K_IRET);
    c_lret: cover property (@(posedge mclk) fire && kind == RIE_K_LRET);
    c_sret: cover property (@(posedge mclk) fire && kind == RIE_K_SRET);
    c_refused: cover property (@(posedge mclk) busy && instr_valid && ctl.pop);
    c_frozen: cover property (@(posedge mclk) !rst && !ce && instr_valid && ctl.pop);
endmodule

// ==== rie_params.svh ====
// How it works
// RULE1: Interrupt return opcode pops the stack and loads the program counter.
// RULE2: Interrupt return sets global interrupt enable, bit 7 of irq control.
// RULE3: Interrupt return is one word and takes two instruction cycles.
// RULE4: Literal return loads accumulator with low eight instruction bits; x bits ignored.
// RULE5: Literal return also pops the stack into the program counter.
// RULE6: Literal return is one word and takes two instruction cycles.
// RULE7: Subroutine return pops stack into program counter, interrupt enable untouched.
// RULE8: Subroutine return is one word and takes two instruction cycles.
// RULE9: A program counter change is followed by one no-operation cycle.
// RULE10: Each instruction cycle spans four oscillator periods.
// RULE11: No return instruction touches any arithmetic status flag.
`ifndef RIE_PARAMS_SVH
`define RIE_PARAMS_SVH
`define RIE_OP_IRET 14'h0009
`define RIE_OP_SRET 14'h0008
`define RIE_OP_LRET_MASK 14'h3C00
`define RIE_OP_LRET_VAL 14'h3400
`define RIE_GIE_BIT 7
`define RIE_OSC_PER_CYC 4
`define RIE_PC_RST 13'h0000
`define RIE_ACC_RST 8'h00
`define RIE_IRQ_RST 8'h00
`endif

// ==== rie_pkg.sv ====
package rie_pkg;
    typedef enum logic [1:0] {
        RIE_EXEC = 2'b00,
        RIE_FLUSH = 2'b01
    } rie_state_t;
    typedef enum logic [1:0] {
        RIE_K_NONE = 2'b00,
        RIE_K_IRET = 2'b01,
        RIE_K_LRET = 2'b10,
        RIE_K_SRET = 2'b11
    } rie_kind_t;
    // Effects of one decoded return instruction
    typedef struct packed {
        logic pop;
        logic set_gie;
        logic load_acc;
        logic [7:0] literal;
    } rie_ctl_t;
endpackage

// ==== rie_decode.sv ====
`timescale 1ns/1ps
`include "rie_params.svh"
module rie_decode
    import rie_pkg::*;
(
    input wire logic [13:0] instr,
    output rie_kind_t kind,
    output rie_ctl_t ctl
);
    wire is_iret = (instr == `RIE_OP_IRET);
    wire is_sret = (instr == `RIE_OP_SRET);
    // RULE4 x bits ignored
    wire is_lret = ((instr & `RIE_OP_LRET_MASK) == `RIE_OP_LRET_VAL);
    assign kind = is_iret ? RIE_K_IRET : is_lret ? RIE_K_LRET :
                  is_sret ? RIE_K_SRET : RIE_K_NONE;
    // RULE1 RULE5 RULE7 pop
    assign ctl.pop = is_iret | is_lret | is_sret;
    // RULE2 RULE7 gie only iret
    assign ctl.set_gie = is_iret;
    // RULE4 literal load
    assign ctl.load_acc = is_lret;
    assign ctl.literal = instr[7:0];
endmodule

// ==== rie_stack_model.sv ====
`timescale 1ns/1ps
module rie_stack_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stack_pop,
    output logic [12:0] stack_top
);
    logic [2:0] sp_ff;
    // Each depth shows its own return address
    assign stack_top = {sp_ff, 10'h2A5};
    // Pop steps down one entry
    always_ff @(posedge mclk) begin
        if (rst)
            sp_ff <= 3'h7;
        else if (stack_pop)
            sp_ff <= sp_ff - 3'h1;
    end
endmodule

// ==== return_instruction_exec_test.sv ====
`timescale 1ns/1ps
module return_instruction_exec_test;
    import rie_pkg::*;
    logic mclk = 0, rst = 1, ce = 1, instr_valid = 0, stack_pop, pc_load, acc_load;
    logic irq_control_we, status_we, busy, cycle_end;
    logic [13:0] instr = 14'h0000;
    logic [12:0] stack_top, pc_ff;
    logic [7:0] irq_control_in = 8'h15, acc_ff, irq_control_reg;
    logic [1:0] osc_phase_ff;
    logic [2:0] exp_sp = 3'h7;
    int mismatches = 0;
    int cmp_count = 0;
    rie_core i_rie_core (.mclk, .rst, .ce, .instr, .instr_valid, .stack_top, .irq_control_in,
        .stack_pop, .pc_ff, .pc_load, .acc_ff, .acc_load, .irq_control_reg, .irq_control_we,
        .status_we, .busy, .cycle_end, .osc_phase_ff);
    rie_stack_model i_rie_stack_model (.mclk, .rst, .stack_pop, .stack_top);
    always #5 mclk = ~mclk;
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    // Issue one word, then judge the firing cycle and the flush cycle
    task automatic exec(input logic [13:0] op, input logic ret, iret, lret);
        logic [12:0] pc0;
        int n;
        pc0 = pc_ff;
        n = 0;
        instr = op;
        instr_valid = 1;
        while (cycle_end !== 1'b1) begin
            tick();
            n++;
            if (n > 8) begin
                mismatches++;
                print_verdict();
            end
        end
        check(osc_phase_ff, 13'h3);
        check(stack_pop, ret);
        check(pc_load, ret);
        check(irq_control_we, iret);
        check(acc_load, lret);
        check(status_we, 0);
        tick();
        check(pc_ff, ret ? {exp_sp, 10'h2A5} : pc0);
        if (ret)
            exp_sp--;
        if (lret)
            check(acc_ff, op[7:0]);
        // Set by the first interrupt return, kept by every later word
        check(irq_control_reg, 8'h95);
        // Request kept up through the flush so a refusal is seen
        repeat (4) begin
            check(busy, ret);
            check(stack_pop, 0);
            tick();
        end
        check(busy, 0);
        instr_valid = 0;
        tick();
    endtask
    task automatic t_iret();
        exec(14'h0009, 1, 1, 0);
    endtask
    task automatic t_lret();
        exec(14'h37FF, 1, 0, 1);
        exec(14'h34A0, 1, 0, 1);
    endtask
    task automatic t_sret();
        exec(14'h0008, 1, 0, 0);
    endtask
    task automatic t_other();
        exec(14'h000A, 0, 0, 0);
        exec(14'h3800, 0, 0, 0);
    endtask
    // Hold a return word with the clock enable low: nothing may move
    task automatic t_freeze();
        logic [1:0] ph;
        logic [12:0] pc0;
        ph = osc_phase_ff;
        pc0 = pc_ff;
        ce = 0;
        instr = 14'h0008;
        instr_valid = 1;
        repeat (6) begin
            tick();
            check(cycle_end, 0);
            check(stack_pop, 0);
        end
        check(osc_phase_ff, ph);
        check(pc_ff, pc0);
        ce = 1;
        instr_valid = 0;
        tick();
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        rst = 0;
        t_iret();
        t_lret();
        t_sret();
        t_other();
        t_freeze();
        t_sret();
        print_verdict();
    end
endmodule
